// [pkg/rsc_pkg.sv]
`default_nettype none
package rsc_pkg;
  // Register map of the block over APB.
  localparam logic [7:0] RCC_ADDR = 8'h00;
  localparam int RCC_WIDTH = 16;
  // Bit positions inside reset_cause_control.
  localparam int TRAP_BIT = 15;
  localparam int BADOP_BIT = 14;
  localparam int REG_KEEP_BIT = 8;
  localparam int PIN_BIT = 7;
  localparam int INSTR_BIT = 6;
  localparam int SWDT_BIT = 5;
  localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int SLEEP_BIT = 3;
  localparam int IDLE_BIT = 2;
  localparam int BOR_BIT = 1;
  localparam int POR_BIT = 0;
  // Implemented bits; bits 13 to 9 always read zero.
  localparam logic [15:0] RCC_WMASK = 16'hC1FF;
  // Flags that a brown-out clears.
  localparam logic [15:0] RCC_BOR_CLR = 16'hC05C;
  localparam logic [15:0] RCC_POR_VALUE = 16'h0003;
  // Reset delays in ns, and the clock period in ns.
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_DELAY_NS = 10000;
  localparam int STARTUP_NS = 20000;
  localparam int STATE_RST_NS = 20000;
  // Least times round up to whole cycles.
  localparam int POR_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC = (STATE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [11:0] DLY_POR = 12'(POR_CYC + START_CYC + RST_CYC);
  localparam logic [11:0] DLY_BOR = 12'(START_CYC + RST_CYC);
  localparam logic [11:0] DLY_RST = 12'(RST_CYC);
  localparam logic [2:0] OSC_RESET = 3'h0;
  // Phases of the master reset.
  typedef enum logic {
    RSC_RUN,
    RSC_HOLD
  } rsc_phase_type;
endpackage
`default_nettype wire

// [verilog/rsc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module rsc_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic brown_out_i,
  input wire logic external_clear_pin_i,
  input wire logic instr_reset_i,
  input wire logic watchdog_reset_i,
  input wire logic trap_conflict_i,
  input wire logic bad_opcode_pointer_i,
  input wire logic power_save_sleep_i,
  input wire logic power_save_idle_i,
  input wire logic watchdog_fuse_enable_i,
  input wire logic clock_switch_enable_i,
  input wire logic [2:0] initial_osc_select_fuse_i,
  input wire logic [2:0] current_osc_field_i,
  output logic master_system_reset_o,
  output logic watchdog_run_o,
  output logic regulator_sleep_keep_o,
  output logic [2:0] osc_select_o
);
  logic [15:0] rcc_q;
  logic [15:0] rcc_d;
  logic pready_q;
  logic pready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  rsc_pkg::rsc_phase_type phase_q;
  rsc_pkg::rsc_phase_type phase_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic por_seen_q;
  logic por_seen_d;
  logic bor_seen_q;
  logic bor_seen_d;
  logic [2:0] osc_q;
  logic [2:0] osc_d;
  logic wdt_run_q;
  logic wdt_run_d;
  logic msr_q;
  logic msr_d;
  logic any_src;
  logic hit;
  logic wr_acc;

  // Power-on comes in as srst_i; the others are sampled every cycle.
  assign any_src = brown_out_i | external_clear_pin_i | instr_reset_i | watchdog_reset_i |
                   trap_conflict_i | bad_opcode_pointer_i;
  assign hit = (paddr_i == rsc_pkg::RCC_ADDR);
  assign wr_acc = psel_i & penable_i & pready_q & pwrite_i & hit;

  // APB slave answers with one access cycle, decoded in the setup cycle.
  always_comb begin
    pready_d = psel_i & ~penable_i;
    pslverr_d = psel_i & ~penable_i & ~hit;
    prdata_d = prdata_q;
    if (psel_i && !penable_i) begin
      prdata_d = hit ? {16'h0000, rcc_q & rsc_pkg::RCC_WMASK} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Flag register: writes first, then hardware clears, then hardware sets.
  // Applying sets last means a software clear never hides a reset event.
  always_comb begin
    rcc_d = rcc_q;
    if (wr_acc) begin
      rcc_d = pwdata_i[15:0] & rsc_pkg::RCC_WMASK;
    end
    if (power_save_sleep_i || power_save_idle_i) begin
      rcc_d[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
    end
    if (brown_out_i) begin
      rcc_d = rcc_d & ~rsc_pkg::RCC_BOR_CLR;
    end
    if (trap_conflict_i) begin
      rcc_d[rsc_pkg::TRAP_BIT] = 1'b1;
    end
    if (bad_opcode_pointer_i) begin
      rcc_d[rsc_pkg::BADOP_BIT] = 1'b1;
    end
    if (external_clear_pin_i) begin
      rcc_d[rsc_pkg::PIN_BIT] = 1'b1;
    end
    if (instr_reset_i) begin
      rcc_d[rsc_pkg::INSTR_BIT] = 1'b1;
    end
    if (watchdog_reset_i) begin
      rcc_d[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
    end
    if (power_save_sleep_i) begin
      rcc_d[rsc_pkg::SLEEP_BIT] = 1'b1;
    end
    if (power_save_idle_i) begin
      rcc_d[rsc_pkg::IDLE_BIT] = 1'b1;
    end
    if (brown_out_i) begin
      rcc_d[rsc_pkg::BOR_BIT] = 1'b1;
    end
  end

  // Power-on is the only hardware event that reaches the enable and regulator bits.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rcc_q <= rsc_pkg::RCC_POR_VALUE;
    end else begin
      rcc_q <= rcc_d;
    end
  end

  // Master reset phase: any source raises the count to its delay if lower, release at zero.
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    por_seen_d = por_seen_q;
    bor_seen_d = bor_seen_q | brown_out_i;
    case (phase_q)
      rsc_pkg::RSC_RUN: begin
        if (any_src) begin
          phase_d = rsc_pkg::RSC_HOLD;
          cnt_d = brown_out_i ? rsc_pkg::DLY_BOR : rsc_pkg::DLY_RST;
        end
      end
      rsc_pkg::RSC_HOLD: begin
        if (any_src) begin
          if (brown_out_i && cnt_q < rsc_pkg::DLY_BOR) begin
            cnt_d = rsc_pkg::DLY_BOR;
          end else if (cnt_q < rsc_pkg::DLY_RST) begin
            cnt_d = rsc_pkg::DLY_RST;
          end
        end else if (cnt_q != 12'h000) begin
          cnt_d = cnt_q - 12'h001;
        end else begin
          phase_d = rsc_pkg::RSC_RUN;
          por_seen_d = 1'b0;
          bor_seen_d = 1'b0;
        end
      end
      default: begin
        phase_d = rsc_pkg::RSC_HOLD;
        cnt_d = rsc_pkg::DLY_RST;
      end
    endcase
    // The pin copy follows the next phase so the output comes straight from a flop.
    msr_d = (phase_d == rsc_pkg::RSC_HOLD);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_q <= rsc_pkg::RSC_HOLD;
      msr_q <= 1'b1;
      cnt_q <= rsc_pkg::DLY_POR;
      por_seen_q <= 1'b1;
      bor_seen_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      msr_q <= msr_d;
      cnt_q <= cnt_d;
      por_seen_q <= por_seen_d;
      bor_seen_q <= bor_seen_d;
    end
  end

  // Clock source tracks its selection while held in reset, then freezes.
  // The fuse is read only after srst_i falls, since it is a live input.
  always_comb begin
    osc_d = osc_q;
    if (phase_q == rsc_pkg::RSC_HOLD || any_src) begin
      if (!clock_switch_enable_i || por_seen_q || bor_seen_q || brown_out_i) begin
        osc_d = initial_osc_select_fuse_i;
      end else begin
        osc_d = current_osc_field_i;
      end
    end
    wdt_run_d = watchdog_fuse_enable_i | rcc_q[rsc_pkg::SWDT_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_q <= rsc_pkg::OSC_RESET;
      wdt_run_q <= 1'b1;
    end else begin
      osc_q <= osc_d;
      wdt_run_q <= wdt_run_d;
    end
  end

  assign pready_o = pready_q;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;
  // The master reset copy always equals the phase, one flop each, no decode on the pin.
  assign master_system_reset_o = msr_q;
  assign watchdog_run_o = wdt_run_q;
  assign regulator_sleep_keep_o = rcc_q[rsc_pkg::REG_KEEP_BIT];
  assign osc_select_o = osc_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence apb_write_s;
    psel_i && !penable_i && pwrite_i && hit ##1 psel_i && penable_i;
  endsequence

  sequence quiet_s;
    !any_src && !master_system_reset_o;
  endsequence

  // No hardware event touches the flag register in this cycle.
  // Used to isolate a software write from the sets and clears that outrank it.
  sequence hw_quiet_s;
    !any_src && !power_save_sleep_i && !power_save_idle_i;
  endsequence

  // The setup cycle of a read that hits the register.
  sequence apb_read_s;
    psel_i && !penable_i && !pwrite_i && hit;
  endsequence

  // The checks below watch only what the block drives.
  // Power-on reset disables them all, since every flop is reloaded then.
  // Source inputs are levels; each check reacts to every cycle a source is seen.

  src_asserts_rst_a: assert property (any_src |=> master_system_reset_o)
    else $error("reset source did not assert master reset");
  rst_hold_cnt_a: assert property (master_system_reset_o && cnt_q != 12'h000
      |=> master_system_reset_o)
    else $error("master reset released before delay expired");
  rst_rel_delay_a: assert property (master_system_reset_o && !any_src && cnt_q == 12'h002
      ##1 !any_src[*2] |=> !master_system_reset_o)
    else $error("master reset not released at end of delay");
  por_value_a: assert property (@(posedge clk_i) $fell(srst_i) |-> rcc_q == 16'h0003)
    else $error("flags wrong after power-on");
  trap_set_a: assert property (trap_conflict_i |=> rcc_q[15])
    else $error("trap flag not set");
  bor_clear_a: assert property (brown_out_i && !trap_conflict_i && !bad_opcode_pointer_i &&
      !instr_reset_i && !wr_acc |=> rcc_q[15:14] == 2'b00 && !rcc_q[6] && rcc_q[1])
    else $error("brown-out did not clear or set its flags");
  pin_keep_a: assert property (brown_out_i && rcc_q[7] && !wr_acc |=> rcc_q[7])
    else $error("brown-out cleared pin flag");
  wdt_clear_a: assert property (power_save_sleep_i && !watchdog_reset_i
      |=> !rcc_q[4] && rcc_q[3])
    else $error("sleep entry flags wrong");
  idle_set_a: assert property (power_save_idle_i |=> rcc_q[2])
    else $error("idle flag not set");
  wdt_run_a: assert property (watchdog_fuse_enable_i |=> watchdog_run_o)
    else $error("fuse did not force watchdog on");
  reg_keep_a: assert property (wr_acc |=> regulator_sleep_keep_o == $past(pwdata_i[8]))
    else $error("regulator output differs from bit 8");
  rsvd_zero_a: assert property (prdata_o[31:16] == 16'h0000 && prdata_o[13:9] == 5'h00)
    else $error("unimplemented bits read nonzero");
  osc_fuse_a: assert property (!clock_switch_enable_i && master_system_reset_o
      |=> osc_select_o == $past(initial_osc_select_fuse_i))
    else $error("oscillator not taken from fuse");
  sw_no_rst_a: assert property (quiet_s ##0 apb_write_s ##0 quiet_s
      |=> !master_system_reset_o)
    else $error("register write caused a reset");

  // Each cause flag shows one cycle after its source, whatever software writes then.
  pin_flag_a: assert property (external_clear_pin_i |=> rcc_q[rsc_pkg::PIN_BIT])
    else $error("pin reset flag not set");
  instr_flag_a: assert property (instr_reset_i |=> rcc_q[rsc_pkg::INSTR_BIT])
    else $error("reset instruction flag not set");
  watchdog_timeout_flag_flag_a: assert property (watchdog_reset_i |=> rcc_q[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT])
    else $error("watchdog flag not set");
  badop_flag_a: assert property (bad_opcode_pointer_i |=> rcc_q[rsc_pkg::BADOP_BIT])
    else $error("bad opcode flag not set");
  bor_flag_a: assert property (brown_out_i |=> rcc_q[rsc_pkg::BOR_BIT])
    else $error("brown-out flag not set");

  // With no hardware event in the way, a write lands exactly, masked to the implemented bits.
  write_lands_a: assert property (wr_acc ##0 hw_quiet_s
      |=> rcc_q == ($past(pwdata_i[15:0]) & rsc_pkg::RCC_WMASK))
    else $error("register write did not land");

  // Read data is the register image taken at the setup edge.
  read_data_a: assert property (apb_read_s
      |=> prdata_o == {16'h0000, $past(rcc_q) & rsc_pkg::RCC_WMASK})
    else $error("read data differs from register");

  // A missed address answers with an error in the same single access cycle.
  bad_addr_err_a: assert property (psel_i && !penable_i && !hit |=> pready_o && pslverr_o)
    else $error("missed address not refused");

  // Once running, the clock choice is frozen until the next reset.
  osc_frozen_a: assert property (!master_system_reset_o && !any_src |=> $stable(osc_select_o))
    else $error("clock source changed while running");

  // With the fuse clear, software alone decides, one cycle late.
  wdt_off_a: assert property (!watchdog_fuse_enable_i && !rcc_q[rsc_pkg::SWDT_BIT]
      |=> !watchdog_run_o)
    else $error("watchdog running while disabled");
endmodule // rsc_top
`default_nettype wire

// [sim/rsc_source_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Stands in for the reset sources and the power-save strobes of the CPU around the block.
module rsc_source_model (
  input wire logic clk_i,
  input wire logic [7:0] fire_i,
  output logic [7:0] line_o
);
  // A request becomes a one-cycle level launched just after the edge, as real sources do.
  always_ff @(posedge clk_i) begin
    line_o <= fire_i;
  end
endmodule // rsc_source_model
`default_nettype wire

// [sim/test_reset_source_combiner_flags.sv]
`timescale 1ns/100ps
`default_nettype none
module test_reset_source_combiner_flags;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fuse_wdt = 1'b0, sw_en = 1'b1;
  logic [7:0] paddr = 8'h00, fire = 8'h00, line;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic pready, pslverr, msr, wdr, rkeep, err;
  logic [2:0] osc;
  int miscompares = 0, compares = 0, n;
  logic [15:0] flag_exp [5] = '{16'h0080, 16'h0040, 16'h0010, 16'h8000, 16'h4000};
  // The clock toggles each half period of 20 ns.
  always #20 clk_i = ~clk_i;
  rsc_source_model src (.clk_i(clk_i), .fire_i(fire), .line_o(line));
  rsc_top dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .brown_out_i(line[0]),
    .external_clear_pin_i(line[1]), .instr_reset_i(line[2]), .watchdog_reset_i(line[3]),
    .trap_conflict_i(line[4]), .bad_opcode_pointer_i(line[5]), .power_save_sleep_i(line[6]),
    .power_save_idle_i(line[7]), .watchdog_fuse_enable_i(fuse_wdt),
    .clock_switch_enable_i(sw_en), .initial_osc_select_fuse_i(3'h2),
    .current_osc_field_i(3'h5), .master_system_reset_o(msr), .watchdog_run_o(wdr),
    .regulator_sleep_keep_o(rkeep), .osc_select_o(osc));
  // Compares one value and reports a difference at once.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high, with a bounded wait.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      complete_run;
    end
  endtask
  task automatic wr16(input logic [15:0] v);
    apb(1'b1, rsc_pkg::RCC_ADDR, {16'h0000, v});
  endtask
  task automatic rd16(input string name, input logic [15:0] exp);
    apb(1'b0, rsc_pkg::RCC_ADDR, 32'h0);
    chk(name, rdata, {16'h0000, exp});
  endtask
  // Pulses sources for one cycle and lets the block see them.
  task automatic pulse(input logic [7:0] m);
    fire <= m;
    @(posedge clk_i);
    fire <= 8'h00;
    repeat (2) @(posedge clk_i);
  endtask
  // The hold is counted from just after the source drops, so a small slack is allowed.
  task automatic wait_rel(input int dly);
    n = 0;
    while (msr !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk("release_delay", 32'(n > dly - 6 && n < dly + 6), 32'h1);
  endtask
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence: power-on, software access, each reset source, power-save, fixed clock.
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    wait_rel(1252);
    chk("osc_por", {29'h0, osc}, 32'h2);
    rd16("rcc_por", 16'h0003);
    chk("wdt_off", {31'h0, wdr}, 32'h0);
    wr16(16'hFFFF);
    rd16("rcc_all", 16'hC1FF);
    chk("no_reset", {31'h0, msr}, 32'h0);
    chk("wdt_soft", {31'h0, wdr}, 32'h1);
    chk("reg_keep", {31'h0, rkeep}, 32'h1);
    wr16(16'h0000);
    rd16("rcc_clear", 16'h0000);
    fuse_wdt <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("wdt_fuse", {31'h0, wdr}, 32'h1);
    chk("reg_standby", {31'h0, rkeep}, 32'h0);
    fuse_wdt <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("bad_addr_err", {31'h0, err}, 32'h1);
    chk("bad_addr_data", rdata, 32'h0);
    // Software clears the causes before each new reset so that only one flag shows.
    for (int i = 0; i < 5; i++) begin
      wr16(16'h0000);
      pulse(8'h02 << i);
      chk("master_held", {31'h0, msr}, 32'h1);
      wait_rel(500);
      rd16("rcc_cause", flag_exp[i]);
      chk("osc_keep", {29'h0, osc}, 32'h5);
    end
    wr16(16'hC0FC);
    pulse(8'h01);
    chk("master_bor", {31'h0, msr}, 32'h1);
    wait_rel(1000);
    rd16("rcc_bor", 16'h00A2);
    chk("osc_bor", {29'h0, osc}, 32'h2);
    wr16(16'h0010);
    pulse(8'h40);
    rd16("rcc_sleep", 16'h0008);
    pulse(8'h80);
    rd16("rcc_idle", 16'h000C);
    chk("no_reset_ps", {31'h0, msr}, 32'h0);
    sw_en <= 1'b0;
    pulse(8'h02);
    wait_rel(500);
    chk("osc_fixed", {29'h0, osc}, 32'h2);
    complete_run;
  end
  // Cuts a hang short far beyond the roughly five and a half thousand cycles the run needs.
  initial begin
    #2000000;
    miscompares++;
    complete_run;
  end
endmodule // test_reset_source_combiner_flags
`default_nettype wire
